//--- metering_peak_status_consts.vh
// offsets, field positions, reset values and timing for the peak/status bank
`ifndef METERING_PEAK_STATUS_CONSTS_VH
`define METERING_PEAK_STATUS_CONSTS_VH
`define ADDR_CURRENT_PEAK   16'he500
`define ADDR_VOLTAGE_PEAK   16'he501
`define ADDR_EVENT_STATUS   16'he502
`define PEAK_VALUE_MSB      23
`define PEAK_TAG_LSB        24
`define PEAK_TAG_MSB        26
`define PEAK_RESET          32'h00000000
`define STATUS_WIDTH        19
`define STATUS_RESET        19'h00000
`define BIT_TOTAL_ACT_HALF  0
`define BIT_FUND_ACT_HALF   1
`define BIT_TOTAL_REA_HALF  2
`define BIT_FUND_REA_HALF   3
`define BIT_APPARENT_HALF   4
`define BIT_LINE_CYCLE      5
`define BIT_ACT_SIGN_A      6
`define BIT_SUM_ONE_SIGN    9
`define BIT_REA_SIGN_A      10
`define BIT_SUM_TWO_SIGN    13
`define BIT_PULSE_ONE       14
`define BIT_COMPUTE_DONE    17
`define BIT_SUM_THREE_SIGN  18
`define PULSE_SEL_ONE_LSB   0
`define PULSE_SEL_TWO_LSB   3
`define PULSE_SEL_THREE_LSB 6
`define PULSE_DIS_ONE_BIT   9
`define PULSE_DIS_TWO_BIT   10
`define PULSE_DIS_THREE_BIT 11
`define COMPUTE_RATE_HZ     8000
`define CLOCK_RATE_HZ       50000000
`endif

//--- edge_event_flag.v
// sticky event flag with edge detect on its source, set wins over clear
`timescale 1ns/1ps
module edge_event_flag #(
  parameter FALLING = 0
) (
  // clock and reset
  input  wire clock,
  input  wire rst_n,
  input  wire clock_enable,
  // source and control
  input  wire source_level,
  input  wire enable,
  input  wire clear,
  // flag
  output reg  flag
);
  reg  last_level;
  wire edge_seen;

  // rising or falling edge depending on polarity
  assign edge_seen = FALLING ? (last_level & ~source_level)
                             : (~last_level & source_level);

  // remember source and hold flag until cleared
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_level <= 1'b0;
      flag       <= 1'b0;
    end else if (clock_enable) begin
      last_level <= source_level;
      if (enable & edge_seen)
        flag <= 1'b1;
      else if (clear)
        flag <= 1'b0;
    end
  end
endmodule // edge_event_flag

//--- metering_peak_status_regs.v
// peak capture and first event status registers of the metering core
//
// Contract
// - current peak magnitude in bits 23:0
// - one-hot current peak phase tag bits 24-26
// - peak registers read zero in bits 31:27
// - voltage peak magnitude in bits 23:0
// - one-hot voltage peak phase tag bits 24-26
// - bit 0: total active energy bit30 toggled
// - bit 1: fundamental active bit30, variant gated
// - bit 2: total reactive bit30, variant gated
// - bit 3: fundamental reactive bit30, variant gated
// - bit 4: apparent energy bit30 toggled
// - bit 5: line-cycle accumulation finished
// - bits 6-8: selected active power sign change
// - bits 10-12: selected reactive sign change, gated
// - bits 9,13,18: pulse sum power sign change
// - bits 14-16: pulse output falling edge
// - pulse flags set even when output disabled
// - pulse source select fields in mode register
// - bit 17: periodic computation pass done
// - status bits 31:19 read zero
`timescale 1ns/1ps
`include "metering_peak_status_consts.vh"
module metering_peak_status_regs #(
  parameter HAS_FUNDAMENTAL = 1,
  parameter HAS_REACTIVE    = 1
) (
  // clock, reset and enable
  input  wire        clock,
  input  wire        rst_n,
  input  wire        clock_enable,
  // register port from the serial interface
  input  wire [15:0] reg_addr,
  input  wire        reg_read,
  input  wire        reg_write,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  // peak detector results
  input  wire        current_peak_update,
  input  wire [23:0] current_peak_in,
  input  wire [1:0]  current_peak_phase,
  input  wire        voltage_peak_update,
  input  wire [23:0] voltage_peak_in,
  input  wire [1:0]  voltage_peak_phase,
  // energy accumulator bit 30, three phases each
  input  wire [2:0]  total_active_bit30,
  input  wire [2:0]  fund_active_bit30,
  input  wire [2:0]  total_reactive_bit30,
  input  wire [2:0]  fund_reactive_bit30,
  input  wire [2:0]  apparent_bit30,
  // line cycle and compute pass strobes
  input  wire        line_cycle_end,
  input  wire        accumulation_mode_line,
  input  wire        compute_pass_end,
  // power signs: total and fundamental, phases a-c
  input  wire        active_sign_selector,
  input  wire        reactive_sign_selector,
  input  wire [2:0]  total_active_sign,
  input  wire [2:0]  fund_active_sign,
  input  wire [2:0]  total_reactive_sign,
  input  wire [2:0]  fund_reactive_sign,
  input  wire [2:0]  pulse_sum_sign,
  // pulse outputs and their mode register
  input  wire [2:0]  pulse_output_level,
  input  wire [11:0] pulse_mode_register,
  // selected power source and output gate for each pulse output
  output reg  [2:0]  pulse_one_source_select,
  output reg  [2:0]  pulse_two_source_select,
  output reg  [2:0]  pulse_three_source_select,
  output reg  [2:0]  pulse_output_gate
);
  reg  [23:0] current_peak_value;
  reg  [2:0]  current_peak_phase_tag;
  reg  [23:0] voltage_peak_value;
  reg  [2:0]  voltage_peak_phase_tag;
  reg  [`STATUS_WIDTH-1:0] clear_vec;
  reg  [2:0]  next_current_tag;
  reg  [2:0]  next_voltage_tag;
  reg  [31:0] next_rdata;
  wire [`STATUS_WIDTH-1:0] event_status_first;
  wire [`STATUS_WIDTH-1:0] src_level;
  wire [`STATUS_WIDTH-1:0] src_enable;
  wire [2:0]  active_sel_sign;
  wire [2:0]  reactive_sel_sign;
  wire        fund_ok;
  wire        reactive_ok;
  wire        line_pulse;
  wire        status_write;

  assign fund_ok      = (HAS_FUNDAMENTAL != 0);
  assign reactive_ok  = (HAS_REACTIVE != 0);
  assign status_write = reg_write & (reg_addr == `ADDR_EVENT_STATUS);
  assign line_pulse   = line_cycle_end & accumulation_mode_line;

  // signs picked by the total/fundamental selectors
  assign active_sel_sign   = active_sign_selector ? fund_active_sign
                                                  : total_active_sign;
  assign reactive_sel_sign = reactive_sign_selector ? fund_reactive_sign
                                                    : total_reactive_sign;

  // one-hot phase tag from the phase index
  always @* begin
    next_current_tag = 3'h0;
    next_voltage_tag = 3'h0;
    case (current_peak_phase)
      2'h0:    next_current_tag = 3'h1;
      2'h1:    next_current_tag = 3'h2;
      2'h2:    next_current_tag = 3'h4;
      default: next_current_tag = 3'h0;
    endcase
    case (voltage_peak_phase)
      2'h0:    next_voltage_tag = 3'h1;
      2'h1:    next_voltage_tag = 3'h2;
      2'h2:    next_voltage_tag = 3'h4;
      default: next_voltage_tag = 3'h0;
    endcase
  end

  // peak capture registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      current_peak_value     <= 24'h000000;
      current_peak_phase_tag <= 3'h0;
      voltage_peak_value     <= 24'h000000;
      voltage_peak_phase_tag <= 3'h0;
    end else if (clock_enable) begin
      if (current_peak_update) begin
        current_peak_value     <= current_peak_in;
        current_peak_phase_tag <= next_current_tag;
      end
      if (voltage_peak_update) begin
        voltage_peak_value     <= voltage_peak_in;
        voltage_peak_phase_tag <= next_voltage_tag;
      end
    end
  end

  // event sources; toggles of bit 30 seen as either edge of the xor
  assign src_level[`BIT_TOTAL_ACT_HALF] = ^total_active_bit30;
  assign src_level[`BIT_FUND_ACT_HALF]  = ^fund_active_bit30;
  assign src_level[`BIT_TOTAL_REA_HALF] = ^total_reactive_bit30;
  assign src_level[`BIT_FUND_REA_HALF]  = ^fund_reactive_bit30;
  assign src_level[`BIT_APPARENT_HALF]  = ^apparent_bit30;
  assign src_level[`BIT_LINE_CYCLE]     = line_pulse;
  assign src_level[`BIT_ACT_SIGN_A+2:`BIT_ACT_SIGN_A] = active_sel_sign;
  assign src_level[`BIT_SUM_ONE_SIGN]   = pulse_sum_sign[0];
  assign src_level[`BIT_REA_SIGN_A+2:`BIT_REA_SIGN_A] = reactive_sel_sign;
  assign src_level[`BIT_SUM_TWO_SIGN]   = pulse_sum_sign[1];
  assign src_level[`BIT_PULSE_ONE+2:`BIT_PULSE_ONE] = pulse_output_level;
  assign src_level[`BIT_COMPUTE_DONE]   = compute_pass_end;
  assign src_level[`BIT_SUM_THREE_SIGN] = pulse_sum_sign[2];

  // variant gating; pulse flags ignore the disable bits
  assign src_enable[`BIT_TOTAL_ACT_HALF] = 1'b1;
  assign src_enable[`BIT_FUND_ACT_HALF]  = fund_ok;
  assign src_enable[`BIT_TOTAL_REA_HALF] = reactive_ok;
  assign src_enable[`BIT_FUND_REA_HALF]  = fund_ok & reactive_ok;
  assign src_enable[`BIT_REA_SIGN_A-1:`BIT_APPARENT_HALF] = 6'h3f;
  assign src_enable[`BIT_REA_SIGN_A+2:`BIT_REA_SIGN_A] =
           {3{reactive_ok}};
  assign src_enable[`STATUS_WIDTH-1:`BIT_SUM_TWO_SIGN] = 6'h3f;

  // write-one-to-clear mask from the host
  always @* begin
    clear_vec = {`STATUS_WIDTH{1'b0}};
    if (status_write)
      clear_vec = reg_wdata[`STATUS_WIDTH-1:0];
  end

  // one sticky flag per rise-only or fall-only status bit, two ORed per both-edge bit; sign flags see both edges
  genvar i;
  generate
    for (i = 0; i < `STATUS_WIDTH; i = i + 1) begin : g_flag
      if (i == `BIT_LINE_CYCLE || i == `BIT_COMPUTE_DONE) begin : g_rise
        edge_event_flag #(.FALLING(0)) u_flag (
          .clock        (clock),
          .rst_n        (rst_n),
          .clock_enable (clock_enable),
          .source_level (src_level[i]),
          .enable       (src_enable[i]),
          .clear        (clear_vec[i]),
          .flag         (event_status_first[i])
        );
      end else if (i >= `BIT_PULSE_ONE && i < `BIT_COMPUTE_DONE)
      begin : g_fall
        edge_event_flag #(.FALLING(1)) u_flag (
          .clock        (clock),
          .rst_n        (rst_n),
          .clock_enable (clock_enable),
          .source_level (src_level[i]),
          .enable       (src_enable[i]),
          .clear        (clear_vec[i]),
          .flag         (event_status_first[i])
        );
      end else begin : g_both
        wire rise_flag;
        wire fall_flag;
        edge_event_flag #(.FALLING(0)) u_rise (
          .clock        (clock),
          .rst_n        (rst_n),
          .clock_enable (clock_enable),
          .source_level (src_level[i]),
          .enable       (src_enable[i]),
          .clear        (clear_vec[i]),
          .flag         (rise_flag)
        );
        edge_event_flag #(.FALLING(1)) u_fall (
          .clock        (clock),
          .rst_n        (rst_n),
          .clock_enable (clock_enable),
          .source_level (src_level[i]),
          .enable       (src_enable[i]),
          .clear        (clear_vec[i]),
          .flag         (fall_flag)
        );
        assign event_status_first[i] = rise_flag | fall_flag;
      end
    end
  endgenerate

  // read mux; upper bits are constant zero
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `ADDR_CURRENT_PEAK:
        next_rdata = {5'h00, current_peak_phase_tag,
                      current_peak_value};
      `ADDR_VOLTAGE_PEAK:
        next_rdata = {5'h00, voltage_peak_phase_tag,
                      voltage_peak_value};
      `ADDR_EVENT_STATUS:
        next_rdata = {13'h0000, event_status_first};
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // registered read answer and pulse mode decode
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata                 <= `PEAK_RESET;
      reg_rvalid                <= 1'b0;
      pulse_one_source_select   <= 3'h0;
      pulse_two_source_select   <= 3'h0;
      pulse_three_source_select <= 3'h0;
      pulse_output_gate         <= 3'h0;
    end else if (clock_enable) begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
      pulse_one_source_select <=
        pulse_mode_register[`PULSE_SEL_ONE_LSB+2:`PULSE_SEL_ONE_LSB];
      pulse_two_source_select <=
        pulse_mode_register[`PULSE_SEL_TWO_LSB+2:`PULSE_SEL_TWO_LSB];
      pulse_three_source_select <=
        pulse_mode_register[`PULSE_SEL_THREE_LSB+2:`PULSE_SEL_THREE_LSB];
      pulse_output_gate <= ~{pulse_mode_register[`PULSE_DIS_THREE_BIT],
                             pulse_mode_register[`PULSE_DIS_TWO_BIT],
                             pulse_mode_register[`PULSE_DIS_ONE_BIT]};
    end
  end
endmodule // metering_peak_status_regs

//--- metering_peak_status_regs_assertions.sv
// checker for the peak and status register bank
`timescale 1ns/1ps
module metering_peak_status_checker (
  // watched ports
  input wire        clock,
  input wire        rst_n,
  input wire        clock_enable,
  input wire [15:0] reg_addr,
  input wire        reg_read,
  input wire [31:0] reg_rdata,
  input wire        reg_rvalid,
  input wire [11:0] pulse_mode_register,
  input wire [2:0]  pulse_one_source_select,
  input wire [2:0]  pulse_output_gate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // read answers for the two peak words and the status word
  peak_top_zero_a:
  assert property (reg_rvalid && $past(reg_addr[15:1]) == 15'h7280
    |-> reg_rdata[31:27] == 5'h0) else $error("peak top bits set");
  cur_tag_onehot_a:
  assert property (reg_rvalid && $past(reg_addr) == 16'he500
    |-> $onehot0(reg_rdata[26:24])) else $error("current tag not one-hot");
  volt_tag_onehot_a:
  assert property (reg_rvalid && $past(reg_addr) == 16'he501
    |-> $onehot0(reg_rdata[26:24])) else $error("voltage tag not one-hot");
  status_top_zero_a:
  assert property (reg_rvalid && $past(reg_addr) == 16'he502
    |-> reg_rdata[31:19] == 13'h0) else $error("status upper bits set");
  // pulse mode fields reach the outputs
  pulse_select_copy_a:
  assert property (clock_enable |=> pulse_one_source_select
    == $past(pulse_mode_register[2:0])) else $error("select not copied");
  pulse_gate_copy_a:
  assert property (clock_enable |=> pulse_output_gate
    == ~$past(pulse_mode_register[11:9])) else $error("gate not copied");
  // read handshake timing
  read_answer_a:
  assert property (clock_enable |=> reg_rvalid == $past(reg_read))
    else $error("read answer mistimed");
  rdata_hold_a:
  assert property (clock_enable && !reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule // metering_peak_status_checker

bind metering_peak_status_regs metering_peak_status_checker checker_i (
  .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .pulse_mode_register(pulse_mode_register),
  .pulse_one_source_select(pulse_one_source_select),
  .pulse_output_gate(pulse_output_gate));

//--- test_metering_peak_status_regs.sv
// self-checking bench for the peak and status register bank
`timescale 1ns/1ps
`include "metering_peak_status_consts.vh"
module test_metering_peak_status_regs;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] addr = 16'h0;
  reg         rd = 1'b0, wr = 1'b0, cu = 1'b0, vu = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg  [23:0] cv = 24'h0, vv = 24'h0;
  reg  [1:0]  cp = 2'h0, vp = 2'h0;
  reg  [2:0]  ta = 3'h0, fa = 3'h0, tr = 3'h0, fr = 3'h0, ap = 3'h0;
  reg  [2:0]  tas = 3'h0, fas = 3'h0, trs = 3'h0, ps = 3'h0;
  reg  [2:0]  po = 3'h7;
  reg         lc = 1'b0, cd = 1'b0, asel = 1'b0;
  reg         ce = 1'b1, am = 1'b1, rsel = 1'b0;
  reg  [2:0]  frs = 3'h0;
  reg  [11:0] mode = 12'h0;
  reg  [31:0] got, got2;
  wire [31:0] rdata, rdata2;
  wire        rvalid;
  wire [2:0]  s1, s2, s3, gate;
  integer     bad_count = 0, compares = 0, b;

  // clock
  always #10 clock = ~clock;

  metering_peak_status_regs metering_peak_status_regs_i (
    .clock(clock), .rst_n(rst_n), .clock_enable(ce),
    .reg_addr(addr), .reg_read(rd), .reg_write(wr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid),
    .current_peak_update(cu), .current_peak_in(cv),
    .current_peak_phase(cp), .voltage_peak_update(vu),
    .voltage_peak_in(vv), .voltage_peak_phase(vp),
    .total_active_bit30(ta), .fund_active_bit30(fa),
    .total_reactive_bit30(tr), .fund_reactive_bit30(fr),
    .apparent_bit30(ap), .line_cycle_end(lc),
    .accumulation_mode_line(am), .compute_pass_end(cd),
    .active_sign_selector(asel), .reactive_sign_selector(rsel),
    .total_active_sign(tas), .fund_active_sign(fas),
    .total_reactive_sign(trs), .fund_reactive_sign(frs),
    .pulse_sum_sign(ps), .pulse_output_level(po),
    .pulse_mode_register(mode), .pulse_one_source_select(s1),
    .pulse_two_source_select(s2), .pulse_three_source_select(s3),
    .pulse_output_gate(gate));

  // reduced variant: no fundamental and no reactive measurement
  metering_peak_status_regs #(
    .HAS_FUNDAMENTAL(0), .HAS_REACTIVE(0)
  ) metering_peak_status_regs_lite_i (
    .clock(clock), .rst_n(rst_n), .clock_enable(ce),
    .reg_addr(addr), .reg_read(rd), .reg_write(wr), .reg_wdata(wdata),
    .reg_rdata(rdata2), .reg_rvalid(),
    .current_peak_update(cu), .current_peak_in(cv),
    .current_peak_phase(cp), .voltage_peak_update(vu),
    .voltage_peak_in(vv), .voltage_peak_phase(vp),
    .total_active_bit30(ta), .fund_active_bit30(fa),
    .total_reactive_bit30(tr), .fund_reactive_bit30(fr),
    .apparent_bit30(ap), .line_cycle_end(lc),
    .accumulation_mode_line(am), .compute_pass_end(cd),
    .active_sign_selector(asel), .reactive_sign_selector(rsel),
    .total_active_sign(tas), .fund_active_sign(fas),
    .total_reactive_sign(trs), .fund_reactive_sign(frs),
    .pulse_sum_sign(ps), .pulse_output_level(po),
    .pulse_mode_register(mode), .pulse_one_source_select(),
    .pulse_two_source_select(), .pulse_three_source_select(),
    .pulse_output_gate());

  // compare and count
  task check(input [8*12:1] what, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask

  // one read, answer sampled the cycle after it is taken
  task rd_reg(input [15:0] a, output [31:0] d);
    begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check("rvalid", {31'h0, rvalid}, 32'h1);
      d = rdata;
      got2 = rdata2;
    end
  endtask

  // one write
  task wr_reg(input [15:0] a, input [31:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask

  // all words read zero after reset, unmapped too
  task test_reset;
    begin
      rd_reg(`ADDR_CURRENT_PEAK, got);
      check("cur reset", got, 32'h0);
      rd_reg(`ADDR_VOLTAGE_PEAK, got);
      check("volt reset", got, 32'h0);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("stat reset", got, 32'h0);
      rd_reg(16'he503, got);
      check("unmapped", got, 32'h0);
      $display("test_reset done");
    end
  endtask

  // peak capture with each phase tag, current peak read-only against writes
  task test_peaks;
    begin
      for (b = 0; b < 3; b = b + 1) begin
        @(posedge clock);
        cu <= 1'b1;
        cv <= 24'hffffff - b;
        cp <= b;
        vu <= 1'b1;
        vv <= 24'h123456 + b;
        vp <= 2 - b;
        @(posedge clock);
        cu <= 1'b0;
        vu <= 1'b0;
        wr_reg(`ADDR_CURRENT_PEAK, 32'hffffffff);
        rd_reg(`ADDR_CURRENT_PEAK, got);
        check("cur peak", got, {5'h0, 3'h1 << b, cv});
        rd_reg(`ADDR_VOLTAGE_PEAK, got);
        check("volt peak", got, {5'h0, 3'h4 >> b, vv});
      end
      $display("test_peaks done");
    end
  endtask

  // raise one source, expect its bit alone, then clear it
  task event_bit(input integer n);
    begin
      @(posedge clock);
      case (n)
        0: ta[2] <= ~ta[2];
        1: fa[0] <= ~fa[0];
        2: tr[1] <= ~tr[1];
        3: fr[2] <= ~fr[2];
        4: ap[0] <= ~ap[0];
        5: lc <= 1'b1;
        6, 7, 8: tas[n-6] <= ~tas[n-6];
        9: ps[0] <= ~ps[0];
        13: ps[1] <= ~ps[1];
        18: ps[2] <= ~ps[2];
        10, 11, 12: trs[n-10] <= ~trs[n-10];
        17: cd <= 1'b1;
        default: po[n-14] <= 1'b0;
      endcase
      @(posedge clock);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("status set", got, 32'h1 << n);
      check("lite set", got2, (32'h1 << n) & ~32'h1c0e);
      wr_reg(`ADDR_EVENT_STATUS, 32'h1 << n);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("status clr", got, 32'h0);
      check("lite clr", got2, 32'h0);
    end
  endtask

  // every status bit, pulse outputs disabled meanwhile
  task test_events;
    begin
      @(posedge clock);
      mode <= 12'hfac;
      repeat (2) @(posedge clock);
      #1;
      check("selects", {23'h0, s3, s2, s1}, 32'h1ac);
      check("gate", {29'h0, gate}, 32'h0);
      for (b = 0; b < 19; b = b + 1)
        event_bit(b);
      $display("test_events done");
    end
  endtask

  // fundamental sign selected, clear of one flag keeps the other
  task test_fund_sign;
    begin
      @(posedge clock);
      asel <= 1'b1;
      repeat (3) @(posedge clock);
      wr_reg(`ADDR_EVENT_STATUS, 32'h1c0);
      @(posedge clock);
      fas[1] <= 1'b1;
      ap[1] <= ~ap[1];
      @(posedge clock);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("fund sign", got, 32'h90);
      wr_reg(`ADDR_EVENT_STATUS, 32'h80);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("partial clr", got, 32'h10);
      $display("test_fund_sign done");
    end
  endtask

  // line mode gate, fundamental reactive sign, clock enable freeze
  task test_gating;
    begin
      @(posedge clock);
      lc <= 1'b0;
      am <= 1'b0;
      @(posedge clock);
      lc <= 1'b1;
      repeat (2) @(posedge clock);
      lc <= 1'b0;
      rsel <= 1'b1;
      repeat (2) @(posedge clock);
      wr_reg(`ADDR_EVENT_STATUS, 32'h1c10);
      @(posedge clock);
      am <= 1'b1;
      frs[0] <= 1'b1;
      @(posedge clock);
      rd_reg(`ADDR_EVENT_STATUS, got);
      check("line gated", got, 32'h400);
      check("lite rsign", got2, 32'h0);
      wr_reg(`ADDR_EVENT_STATUS, 32'h400);
      @(posedge clock);
      ce <= 1'b0;
      addr <= `ADDR_EVENT_STATUS;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check("frozen", {31'h0, rvalid}, 32'h0);
      @(posedge clock);
      ce <= 1'b1;
      $display("test_gating done");
    end
  endtask

  // verdict
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    test_reset;
    test_peaks;
    test_events;
    test_fund_sign;
    test_gating;
    tally_and_finish;
  end
endmodule // test_metering_peak_status_regs
